// file: hdl/cpp_port.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - each control pin individually input or output
// - mode bit 4 makes pins strobe inputs
// - input full flag bit 7 marks unread word
// - overflow bit 5 on write over unread
// - overflow stays until software writes zero
// - direction bits 2,1,0: select, write, read
// - one register: mode, flags and directions
module cpp_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cpp_pkg::APB_AW-1:0] paddr,
  input wire logic [cpp_pkg::APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [cpp_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // control pins: read strobe, write strobe, select
  input wire logic [cpp_pkg::NPIN-1:0] control_pin_in,
  output logic [cpp_pkg::NPIN-1:0] control_pin_out,
  output logic [cpp_pkg::NPIN-1:0] control_pin_oe_n,
  // parallel data pins
  input wire logic [cpp_pkg::DW-1:0] parallel_data_in,
  output logic [cpp_pkg::DW-1:0] parallel_data_out,
  output logic [cpp_pkg::DW-1:0] parallel_data_oe_n,
  // interrupt
  output logic irq
);

  cpp_pkg::cpp_state_t st_ff;
  cpp_pkg::cpp_state_t nxt_st;
  cpp_pkg::cpp_pins_t pins;
  logic [cpp_pkg::SYNC_W-1:0] sync_lvl;
  logic [cpp_pkg::NPIN-1:0] pin_lvl;
  logic [cpp_pkg::DW-1:0] data_lvl;

  function automatic cpp_pkg::cpp_reg_t decode(input logic [cpp_pkg::APB_AW-1:0] a);
    case (a)
      cpp_pkg::ADDR_CTRL: decode = cpp_pkg::CPP_REG_CTRL;
      cpp_pkg::ADDR_PSP_DATA: decode = cpp_pkg::CPP_REG_DATA;
      cpp_pkg::ADDR_PIN_PORT: decode = cpp_pkg::CPP_REG_PIN;
      cpp_pkg::ADDR_IRQ_STAT: decode = cpp_pkg::CPP_REG_STAT;
      cpp_pkg::ADDR_IRQ_MASK: decode = cpp_pkg::CPP_REG_MASK;
      default: decode = cpp_pkg::CPP_REG_NONE;
    endcase
  endfunction

  function automatic logic [7:0] ctrl_image(input cpp_pkg::cpp_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[cpp_pkg::CTRL_IBF] = s.input_buffer_full_flag;
    v[cpp_pkg::CTRL_OBF] = s.output_buffer_full_flag;
    v[cpp_pkg::CTRL_INPUT_OVERFLOW_FLAG] = s.input_overflow_flag;
    v[cpp_pkg::CTRL_MODE] = s.mode;
    v[cpp_pkg::CTRL_DIR_HI:0] = s.dir; // bit 3 stays zero
    ctrl_image = v;
  endfunction

  // strobes and data bus arrive from outside this clock domain
  cpp_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({parallel_data_in, control_pin_in}),
    .level_out(sync_lvl)
  );

  assign pin_lvl = sync_lvl[cpp_pkg::NPIN-1:0];
  assign data_lvl = sync_lvl[cpp_pkg::SYNC_W-1:cpp_pkg::NPIN];

  logic selected;
  logic rd_now;
  logic wr_now;
  logic rd_done;
  logic wr_done;
  logic setup;
  logic access;
  logic wr_ok;
  cpp_pkg::cpp_reg_t rsel;

  // strobes and select are active low and only count in slave port mode
  assign selected = st_ff.mode && !pin_lvl[cpp_pkg::PIN_SEL];
  assign rd_now = selected && !pin_lvl[cpp_pkg::PIN_RD];
  assign wr_now = selected && !pin_lvl[cpp_pkg::PIN_WR];
  // a transfer completes when its strobe (or select) is released
  // a master that drops select before the strobe still completes its word,
  // since selected falls and takes the strobe term with it
  assign rd_done = st_ff.rd_act && !rd_now;
  assign wr_done = st_ff.wr_act && !wr_now;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign rsel = decode(paddr);
  // every register lives in byte lane 0; the other lanes are ignored
  assign wr_ok = access && pwrite && pstrb[0];

  always_comb begin
    logic [7:0] wb;
    logic [2:0] ev;
    wb = pwdata[7:0];
    ev = 3'h0;
    nxt_st = st_ff;
    nxt_st.rd_act = rd_now;
    nxt_st.wr_act = wr_now;

    // read data and error are registered in the setup cycle
    // so the access phase never waits on the address decode
    if (setup) begin
      nxt_st.pslverr = (rsel == cpp_pkg::CPP_REG_NONE);
      case (rsel)
        cpp_pkg::CPP_REG_CTRL: nxt_st.prdata = {24'h00_0000, ctrl_image(st_ff)};
        cpp_pkg::CPP_REG_DATA: nxt_st.prdata = {24'h00_0000, st_ff.in_word};
        cpp_pkg::CPP_REG_PIN: nxt_st.prdata = {29'h0000_0000, pin_lvl};
        cpp_pkg::CPP_REG_STAT: nxt_st.prdata = {29'h0000_0000, st_ff.irq_stat};
        cpp_pkg::CPP_REG_MASK: nxt_st.prdata = {29'h0000_0000, st_ff.irq_mask};
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end

    // software side: clears first, hardware sets below win
    if (wr_ok) begin
      case (rsel)
        cpp_pkg::CPP_REG_CTRL: begin
          nxt_st.mode = wb[cpp_pkg::CTRL_MODE];
          nxt_st.dir = wb[cpp_pkg::CTRL_DIR_HI:0];
          // writing one leaves the flag as it is; only zero clears
          nxt_st.input_overflow_flag = st_ff.input_overflow_flag && wb[cpp_pkg::CTRL_INPUT_OVERFLOW_FLAG];
        end
        cpp_pkg::CPP_REG_DATA: begin
          nxt_st.out_word = wb;
          nxt_st.output_buffer_full_flag = 1'b1;
        end
        cpp_pkg::CPP_REG_PIN: begin
          nxt_st.pin_lat = wb[cpp_pkg::NPIN-1:0];
        end
        cpp_pkg::CPP_REG_STAT: begin
          nxt_st.irq_stat = st_ff.irq_stat & ~wb[2:0];
        end
        cpp_pkg::CPP_REG_MASK: begin
          nxt_st.irq_mask = wb[2:0];
        end
        default: begin
        end
      endcase
    end
    // cpu reading the received word empties the input buffer
    if (access && !pwrite && rsel == cpp_pkg::CPP_REG_DATA) begin
      nxt_st.input_buffer_full_flag = 1'b0;
    end

    // external read finished: output word taken, unless cpu refilled it now
    if (rd_done) begin
      if (!(wr_ok && rsel == cpp_pkg::CPP_REG_DATA)) begin
        nxt_st.output_buffer_full_flag = 1'b0;
      end
      ev[cpp_pkg::IRQ_TX] = 1'b1;
    end
    // external write finished: capture word, flag overflow if still unread
    // an unread word is still overwritten; the overflow flag and the IRQ_OVF status bit record the loss
    if (wr_done) begin
      nxt_st.in_word = data_lvl;
      nxt_st.input_buffer_full_flag = 1'b1;
      ev[cpp_pkg::IRQ_RX] = 1'b1;
      if (st_ff.input_buffer_full_flag) begin
        nxt_st.input_overflow_flag = 1'b1;
        ev[cpp_pkg::IRQ_OVF] = 1'b1;
      end
    end
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= cpp_pkg::STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    pins.ctl_out = st_ff.pin_lat;
    // in slave port mode the pins never drive, whatever the direction bits say
    if (st_ff.mode) begin
      pins.ctl_oe_n = {cpp_pkg::NPIN{1'b1}};
    end else begin
      pins.ctl_oe_n = st_ff.dir; // one means input
    end
    pins.data_out = st_ff.out_word;
    // drive lags the strobe by the synchroniser delay
    pins.data_oe_n = {cpp_pkg::DW{!st_ff.rd_act}};
  end

  assign control_pin_out = pins.ctl_out;
  assign control_pin_oe_n = pins.ctl_oe_n;
  assign parallel_data_out = pins.data_out;
  assign parallel_data_oe_n = pins.data_oe_n;

  assign prdata = st_ff.prdata;
  assign pslverr = st_ff.pslverr;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  // level output: stays high until the status bit or its mask is cleared
  assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule
`default_nettype wire

// file: include/cpp_pkg.sv
package cpp_pkg;

  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // register indices; the byte address is four times the index
  localparam logic [APB_AW-1:0] IDX_CTRL = 12'h0089;
  localparam logic [APB_AW-1:0] IDX_PSP_DATA = 12'h0008;
  localparam logic [APB_AW-1:0] IDX_PIN_PORT = 12'h0009;
  localparam logic [APB_AW-1:0] IDX_IRQ_STAT = 12'h0010;
  localparam logic [APB_AW-1:0] IDX_IRQ_MASK = 12'h0011;
  localparam logic [APB_AW-1:0] ADDR_CTRL = IDX_CTRL << 2;
  localparam logic [APB_AW-1:0] ADDR_PSP_DATA = IDX_PSP_DATA << 2;
  localparam logic [APB_AW-1:0] ADDR_PIN_PORT = IDX_PIN_PORT << 2;
  localparam logic [APB_AW-1:0] ADDR_IRQ_STAT = IDX_IRQ_STAT << 2;
  localparam logic [APB_AW-1:0] ADDR_IRQ_MASK = IDX_IRQ_MASK << 2;

  // control register fields
  localparam int CTRL_IBF = 7;
  localparam int CTRL_OBF = 6;
  localparam int CTRL_INPUT_OVERFLOW_FLAG = 5;
  localparam int CTRL_MODE = 4;
  localparam int CTRL_DIR_HI = 2;
  localparam int PIN_RD = 0;
  localparam int PIN_WR = 1;
  localparam int PIN_SEL = 2;
  localparam logic [2:0] DIR_RESET = 3'h7;

  // interrupt status / mask fields
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVF = 2;

  localparam int NPIN = 3;
  localparam int DW = 8;
  localparam int SYNC_W = NPIN + DW;

  typedef enum logic [2:0] {
    CPP_REG_NONE = 3'b000,
    CPP_REG_CTRL = 3'b001,
    CPP_REG_DATA = 3'b010,
    CPP_REG_PIN = 3'b011,
    CPP_REG_STAT = 3'b100,
    CPP_REG_MASK = 3'b101
  } cpp_reg_t;

  typedef struct packed {
    logic [NPIN-1:0] dir;
    logic mode;
    logic input_buffer_full_flag;
    logic output_buffer_full_flag;
    logic input_overflow_flag;
    logic [NPIN-1:0] pin_lat;
    logic [DW-1:0] in_word;
    logic [DW-1:0] out_word;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [APB_DW-1:0] prdata;
    logic pslverr;
    logic rd_act;
    logic wr_act;
  } cpp_state_t;

  localparam cpp_state_t STATE_RESET = '{
    dir: DIR_RESET, mode: 1'b0, input_buffer_full_flag: 1'b0, output_buffer_full_flag: 1'b0, input_overflow_flag: 1'b0,
    pin_lat: 3'h0, in_word: 8'h00, out_word: 8'h00,
    irq_stat: 3'h0, irq_mask: 3'h0, prdata: 32'h0000_0000,
    pslverr: 1'b0, rd_act: 1'b0, wr_act: 1'b0};

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] lvl;
  } cpp_sync_state_t;

  // pin group that leaves the block: levels plus active-low enables
  typedef struct packed {
    logic [NPIN-1:0] ctl_out;
    logic [NPIN-1:0] ctl_oe_n;
    logic [DW-1:0] data_out;
    logic [DW-1:0] data_oe_n;
  } cpp_pins_t;

endpackage

// file: hdl/cpp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cpp_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // raw pin levels and filtered result
  input wire logic [cpp_pkg::SYNC_W-1:0] async_in,
  output logic [cpp_pkg::SYNC_W-1:0] level_out
);

  cpp_pkg::cpp_sync_state_t st_ff;
  cpp_pkg::cpp_sync_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = async_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // a bit changes only once the second and third stage agree
    for (int i = 0; i < cpp_pkg::SYNC_W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.lvl[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // strobes idle high: resetting to ones keeps a false strobe out of the first cycles
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level_out = st_ff.lvl;

endmodule
`default_nettype wire

// file: bench/cpp_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cpp_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [2:0] control_pin_in,
  input wire logic [2:0] control_pin_oe_n,
  input wire logic [7:0] parallel_data_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic acc;
  assign acc = psel && penable && pready;
  logic wacc;
  assign wacc = acc && pwrite;
  sequence rd_end_s;
    psel && penable && !pwrite;
  endsequence
  sequence idle_s;
    !psel;
  endsequence
  ready_high_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (acc && paddr[11:10] != 2'h0 |-> pslverr) else $error("no slverr");
  bit3_zero_a: assert property (acc && !pwrite && paddr == cpp_pkg::ADDR_CTRL |-> !prdata[3] && prdata[31:8] == 0)
    else $error("ctrl bit3 set");
  rd_hold_a: assert property (rd_end_s ##1 idle_s |-> $stable(prdata)) else $error("prdata moved");
  dir_cause_a: assert property ($changed(control_pin_oe_n) |-> $past(wacc, 1) || $past(wacc, 2))
    else $error("pin enable moved");
  no_read_a: assert property (control_pin_in[0] [*8] |-> parallel_data_oe_n == 8'hff) else $error("drive no read");
  desel_a: assert property (control_pin_in[2] [*8] |-> parallel_data_oe_n == 8'hff) else $error("drive desel");
  oe_whole_a: assert property (parallel_data_oe_n == 8'h00 || parallel_data_oe_n == 8'hff)
    else $error("partial drive");
endmodule
bind cpp_port cpp_sva u_sva (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .control_pin_in(control_pin_in),
  .control_pin_oe_n(control_pin_oe_n), .parallel_data_oe_n(parallel_data_oe_n));
`default_nettype wire

// file: bench/cpp_ext_mp.sv
`timescale 1ns/1ps
`default_nettype none
module cpp_ext_mp (
  // clock
  input wire logic ref_clk,
  // bus level and our drive: ctl is select, write, read
  input wire logic [7:0] data_drv,
  output logic [2:0] ctl,
  output logic [7:0] dout
);
  initial begin
    ctl = 3'h7;
    dout = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [7:0] d, input int len, output logic [7:0] q);
    ctl <= 3'b011;
    dout <= d;
    @(posedge ref_clk);
    ctl <= wr ? 3'b001 : 3'b010;
    repeat (len) @(posedge ref_clk);
    q = data_drv;
    ctl <= 3'b011;
    repeat (6) @(posedge ref_clk);
    ctl <= 3'b111;
    dout <= ~d; // released bus never shows the stale word
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [11:0] a_ctrl = cpp_pkg::ADDR_CTRL;
  localparam logic [11:0] a_data = cpp_pkg::ADDR_PSP_DATA;
  localparam logic [11:0] a_mask = cpp_pkg::ADDR_IRQ_MASK;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [2:0] ctl, pin_out, pin_oe_n;
  logic [7:0] din, dout, doe_n, mq;
  int fail_count, check_count, cyc;
  cpp_port u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .control_pin_in(ctl), .control_pin_out(pin_out), .control_pin_oe_n(pin_oe_n),
    .parallel_data_in(din), .parallel_data_out(dout), .parallel_data_oe_n(doe_n), .irq(irq));
  cpp_ext_mp u_mp (.ref_clk(ref_clk), .data_drv(dout & ~doe_n), .ctl(ctl), .dout(din));
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask
  task automatic t_reset;
    rd(a_ctrl, 32'h0000_0007);
    chk(32'(pin_oe_n), 32'h0000_0007);
    rd(12'hffc, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    apb(1'b1, 12'hffc, 32'h0000_00ff);
    chk(32'(e), 32'h0000_0001);
    rd(cpp_pkg::ADDR_PIN_PORT, 32'h0000_0007);
  endtask
  task automatic t_gpio;
    apb(1'b1, a_ctrl, 32'h0000_000a);
    rd(a_ctrl, 32'h0000_0002);
    pstrb <= 4'h0;
    apb(1'b1, a_ctrl, 32'h0000_0015);
    pstrb <= 4'hf;
    rd(a_ctrl, 32'h0000_0002);
    chk(32'(pin_oe_n), 32'h0000_0002);
    apb(1'b1, cpp_pkg::ADDR_PIN_PORT, 32'h0000_0005);
    @(posedge ref_clk);
    chk(32'(pin_out), 32'h0000_0005);
  endtask
  task automatic t_rx;
    apb(1'b1, a_ctrl, 32'h0000_0017);
    apb(1'b1, a_mask, 32'h0000_0007);
    u_mp.xfer(1'b1, 8'ha5, 6, mq);
    rd(a_ctrl, 32'h0000_0097);
    chk(32'(irq), 32'h0000_0001);
    rd(cpp_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    apb(1'b1, a_mask, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, a_mask, 32'h0000_0007);
    u_mp.xfer(1'b1, 8'h3c, 9, mq);
    rd(a_ctrl, 32'h0000_00b7);
    rd(cpp_pkg::ADDR_IRQ_STAT, 32'h0000_0005);
    rd(a_data, 32'h0000_003c);
    rd(a_ctrl, 32'h0000_0037);
    apb(1'b1, a_ctrl, 32'h0000_0037);
    rd(a_ctrl, 32'h0000_0037);
    apb(1'b1, a_ctrl, 32'h0000_0017);
    rd(a_ctrl, 32'h0000_0017);
    apb(1'b1, cpp_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
    chk(32'(irq), 32'h0000_0000);
  endtask
  task automatic t_tx;
    apb(1'b1, a_data, 32'h0000_005a);
    rd(a_ctrl, 32'h0000_0057);
    u_mp.xfer(1'b0, 8'h00, 8, mq);
    chk(32'(mq), 32'h0000_005a);
    rd(a_ctrl, 32'h0000_0017);
    rd(cpp_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    chk(32'(doe_n), 32'h0000_00ff);
  endtask
  task automatic t_rerst;
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk(32'(irq), 32'h0000_0000);
    rd(a_ctrl, 32'h0000_0007);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_gpio();
    t_rx();
    t_tx();
    t_rerst();
    results();
  end
endmodule
`default_nettype wire
